// >>> scan_test_port_with_output_disable.sv
// Scan test port with emulator event pins and the output-disable condition.
// Assumes tck is the emulator's clock, unrelated to clk; pins pass through
// external pads that combine out, oe and in; host ready and interrupt come
// from the host port logic on clk.
`timescale 1ns/100ps
`include "scan_port_defs.svh"

// Summary of operation
// - Mode select and data in are captured on rising test clock edges.
// - Selected register shifts out on test data out, changing on falling edges.
// - Test data out floats except while a register is shifting.
// - Test reset high hands control of the device to the scan system.
// - Test reset low means functional mode; scan pins are ignored.
// - With test reset high, event pin A is a scan-controlled two-way interrupt.
// - With test reset high, event pin B is a scan-controlled two-way interrupt.
// - With test reset low, event pin B becomes the active-low output kill.
// - Test reset low, pin A high, pin B low floats every driver.
// - Host ready and host interrupt float while output kill is active.
module scan_test_port_with_output_disable (
    input wire logic clk, // System clock, 200 MHz
    input wire logic rst_n, // System reset, active low
    input wire logic tck, // Test clock from emulator
    input wire logic tms, // Test mode select
    input wire logic tdi, // Test data in
    input wire logic test_reset_n, // Test reset pin, low selects functional mode
    output logic tdo_out, // Test data out level
    output logic tdo_oe, // Test data out driver enable
    input wire logic emulator_event_pin_a_in, // Event pin A level
    output logic emulator_event_pin_a_out, // Event pin A drive level
    output logic emulator_event_pin_a_oe, // Event pin A driver enable
    input wire logic emulator_event_pin_b_or_output_kill_in, // Event pin B level
    output logic emulator_event_pin_b_or_output_kill_out, // Event pin B drive level
    output logic emulator_event_pin_b_or_output_kill_oe, // Event pin B driver enable
    input wire logic host_ready_core, // Ready from host port logic
    input wire logic host_int_core, // Interrupt from host port logic
    output logic host_port_ready_out, // Host ready pin level
    output logic host_port_ready_oe, // Host ready driver enable
    output logic host_port_interrupt_out, // Host interrupt pin level
    output logic host_port_interrupt_oe, // Host interrupt driver enable
    output logic scan_control, // Scan system owns the device
    output logic output_kill, // All other output drivers must float
    output logic emu_event_a, // Emulator event A into the core
    output logic emu_event_b // Emulator event B into the core
);

    function automatic logic is_shift(input scan_port_pkg::tap_state_t s);
        is_shift = (s == scan_port_pkg::SHIFT_DR) || (s == scan_port_pkg::SHIFT_IR);
    endfunction : is_shift

    // Test clock domain
    scan_port_pkg::tap_state_t state;
    logic [`IR_W-1:0] ir;
    logic [`IR_W-1:0] next_ir;
    logic [`IR_W-1:0] ir_shift;
    logic [`IR_W-1:0] next_ir_shift;
    logic bypass;
    logic next_bypass;
    scan_port_pkg::emu_ctl_t emu_shift;
    scan_port_pkg::emu_ctl_t next_emu_shift;
    scan_port_pkg::emu_ctl_t emu_ctl;
    scan_port_pkg::emu_ctl_t next_emu_ctl;
    logic emu_sel;
    logic emu_a_tck;
    logic emu_b_tck;
    logic next_tdo;
    logic next_tdo_oe;

    tap_fsm u_tap (
        .tck(tck),
        .test_reset_n(test_reset_n),
        .tms(tms),
        .state(state)
    );

    // Pin levels captured into the control register need their own sync
    sync_bit u_sync_a_tck (
        .clk(tck),
        .rst_n(test_reset_n),
        .d(emulator_event_pin_a_in),
        .q(emu_a_tck)
    );

    sync_bit u_sync_b_tck (
        .clk(tck),
        .rst_n(test_reset_n),
        .d(emulator_event_pin_b_or_output_kill_in),
        .q(emu_b_tck)
    );

    assign emu_sel = (ir == `IR_EMU_CTL);

    always_comb begin
        next_ir = ir;
        next_ir_shift = ir_shift;
        next_bypass = bypass;
        next_emu_shift = emu_shift;
        next_emu_ctl = emu_ctl;
        case (state)
            scan_port_pkg::TEST_LOGIC_RESET: begin
                next_ir = `IR_BYPASS;
                next_emu_ctl = scan_port_pkg::emu_ctl_t'(`EMU_CTL_RESET);
            end
            scan_port_pkg::CAPTURE_IR: next_ir_shift = `IR_CAPTURE;
            scan_port_pkg::SHIFT_IR: next_ir_shift = {tdi, ir_shift[`IR_W-1:1]};
            scan_port_pkg::UPDATE_IR: next_ir = ir_shift;
            scan_port_pkg::CAPTURE_DR: begin
                if (emu_sel) begin
                    next_emu_shift = '{b_out: emu_b_tck, b_oe: emu_ctl.b_oe, a_out: emu_a_tck, a_oe: emu_ctl.a_oe};
                end else begin
                    next_bypass = 1'b0;
                end
            end
            scan_port_pkg::SHIFT_DR: begin
                if (emu_sel) begin
                    next_emu_shift = scan_port_pkg::emu_ctl_t'({tdi, emu_shift[`EMU_W-1:1]});
                end else begin
                    next_bypass = tdi;
                end
            end
            scan_port_pkg::UPDATE_DR: begin
                if (emu_sel) begin
                    next_emu_ctl = emu_shift;
                end
            end
            default: begin
            end
        endcase
    end

    // Test reset low clears the pin directions, freeing pin B for output kill
    always_ff @(posedge tck or negedge test_reset_n) begin
        if (!test_reset_n) begin
            ir <= `IR_BYPASS;
            ir_shift <= `IR_CAPTURE;
            bypass <= 1'b0;
            emu_shift <= scan_port_pkg::emu_ctl_t'(`EMU_CTL_RESET);
            emu_ctl <= scan_port_pkg::emu_ctl_t'(`EMU_CTL_RESET);
        end else begin
            ir <= next_ir;
            ir_shift <= next_ir_shift;
            bypass <= next_bypass;
            emu_shift <= next_emu_shift;
            emu_ctl <= next_emu_ctl;
        end
    end

    assign emulator_event_pin_a_out = emu_ctl.a_out;
    assign emulator_event_pin_a_oe = emu_ctl.a_oe;
    assign emulator_event_pin_b_or_output_kill_out = emu_ctl.b_out;
    assign emulator_event_pin_b_or_output_kill_oe = emu_ctl.b_oe;

    always_comb begin
        if (state == scan_port_pkg::SHIFT_IR) begin
            next_tdo = ir_shift[0];
        end else if (emu_sel) begin
            next_tdo = emu_shift[0];
        end else begin
            next_tdo = bypass;
        end
        next_tdo_oe = is_shift(state);
    end

    // Falling edge launch gives the tester half a period of setup
    always_ff @(negedge tck or negedge test_reset_n) begin
        if (!test_reset_n) begin
            tdo_out <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo_out <= next_tdo;
            tdo_oe <= next_tdo_oe;
        end
    end

    // System clock domain
    logic [`RST_SYNC_W-1:0] rst_pipe;
    logic rst_sync_n;
    scan_port_pkg::pin_in_t pin_raw;
    scan_port_pkg::pin_in_t pin_s;
    logic kill_now;
    logic next_scan_control;
    logic next_output_kill;
    logic next_ready_oe;
    logic next_int_oe;
    logic next_event_a;
    logic next_event_b;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe <= '0;
        end else begin
            rst_pipe <= {rst_pipe[`RST_SYNC_W-2:0], 1'b1};
        end
    end

    assign rst_sync_n = rst_pipe[`RST_SYNC_W-1];
    assign pin_raw = '{test_reset_n: test_reset_n, emu_a: emulator_event_pin_a_in,
                       emu_b: emulator_event_pin_b_or_output_kill_in};

    genvar gi;
    generate
        for (gi = 0; gi < `PIN_W; gi++) begin : g_pin_sync
            sync_bit u_sync (
                .clk(clk),
                .rst_n(rst_sync_n),
                .d(pin_raw[gi]),
                .q(pin_s[gi])
            );
        end
    endgenerate

    always_comb begin
        kill_now = !pin_s.test_reset_n && pin_s.emu_a && !pin_s.emu_b;
        next_scan_control = pin_s.test_reset_n;
        next_output_kill = kill_now;
        next_ready_oe = !kill_now;
        next_int_oe = !kill_now;
        next_event_a = pin_s.test_reset_n && pin_s.emu_a;
        next_event_b = pin_s.test_reset_n && pin_s.emu_b;
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            scan_control <= 1'b0;
            output_kill <= 1'b0;
            host_port_ready_oe <= 1'b0;
            host_port_interrupt_oe <= 1'b0;
            host_port_ready_out <= 1'b0;
            host_port_interrupt_out <= 1'b0;
            emu_event_a <= 1'b0;
            emu_event_b <= 1'b0;
        end else begin
            scan_control <= next_scan_control;
            output_kill <= next_output_kill;
            host_port_ready_oe <= next_ready_oe;
            host_port_interrupt_oe <= next_int_oe;
            host_port_ready_out <= host_ready_core;
            host_port_interrupt_out <= host_int_core;
            emu_event_a <= next_event_a;
            emu_event_b <= next_event_b;
        end
    end

    // Assertions
    sequence tms_five_ones;
        tms [*5];
    endsequence

    sequence ir_update_step;
        state == scan_port_pkg::UPDATE_IR;
    endsequence

    tap_reset_a: assert property (@(posedge tck) disable iff (!test_reset_n)
        tms_five_ones |=> state == scan_port_pkg::TEST_LOGIC_RESET)
        else $error("controller not in reset after five mode-select ones");

    ir_load_a: assert property (@(posedge tck) disable iff (!test_reset_n)
        ir_update_step |=> ir == $past(ir_shift))
        else $error("instruction not loaded at update");

    bypass_capture_a: assert property (@(posedge tck) disable iff (!test_reset_n)
        (state == scan_port_pkg::SHIFT_DR && !emu_sel) |=> bypass == $past(tdi))
        else $error("bypass bit did not take data in");

    tdo_shift_value_a: assert property (@(negedge tck) disable iff (!test_reset_n)
        state == scan_port_pkg::SHIFT_IR |=> tdo_out == $past(ir_shift[0]))
        else $error("data out does not show instruction lsb");

    tdo_float_a: assert property (@(negedge tck) disable iff (!test_reset_n)
        !is_shift(state) |=> !tdo_oe)
        else $error("data out driven outside a shift");

    emu_dir_update_a: assert property (@(posedge tck) disable iff (!test_reset_n)
        (state == scan_port_pkg::UPDATE_DR && emu_sel) |=> emu_ctl == $past(emu_shift))
        else $error("pin direction not set by scan update");

    kill_entry_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (!pin_s.test_reset_n && pin_s.emu_a && !pin_s.emu_b) |=> output_kill)
        else $error("output kill not raised");

    host_float_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        output_kill |-> (!host_port_ready_oe && !host_port_interrupt_oe))
        else $error("host outputs driven during output kill");

    functional_mode_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        !pin_s.test_reset_n |=> (!scan_control && !emu_event_a && !emu_event_b))
        else $error("scan control active in functional mode");

    pin_b_input_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (!pin_s.test_reset_n && !$past(pin_s.test_reset_n, 3)) |-> !emulator_event_pin_b_or_output_kill_oe)
        else $error("pin B driven while test reset low");

    tdo_drive_a: assert property (@(negedge tck) disable iff (!test_reset_n)
        is_shift(state) |=> tdo_oe)
        else $error("data out not driven during a shift");

    kill_exit_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        (pin_s.test_reset_n || !pin_s.emu_a || pin_s.emu_b) |=> !output_kill)
        else $error("output kill raised without the kill condition");

    scan_owner_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
        pin_s.test_reset_n |=> scan_control)
        else $error("scan control missing while test reset high");

endmodule : scan_test_port_with_output_disable

// >>> scan_port_defs.svh
// Constants of the scan test port: instruction codes and register widths.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SCAN_PORT_DEFS_SVH
`define SCAN_PORT_DEFS_SVH

`define IR_W 4
`define IR_CAPTURE 4'h1
`define IR_BYPASS 4'hF
`define IR_EMU_CTL 4'h2
`define EMU_W 4
`define EMU_CTL_RESET 4'h0
`define PIN_W 3
`define RST_SYNC_W 2

`endif

// >>> scan_port_pkg.sv
// Types shared by the scan test port modules.
// Assumes scan_port_defs.svh is on the include path.
`include "scan_port_defs.svh"

package scan_port_pkg;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } tap_state_t;

    // Emulator pin drive control, one scan register
    typedef struct packed {
        logic b_out;
        logic b_oe;
        logic a_out;
        logic a_oe;
    } emu_ctl_t;

    // Raw pin levels that cross into the system clock domain
    typedef struct packed {
        logic test_reset_n;
        logic emu_a;
        logic emu_b;
    } pin_in_t;

endpackage : scan_port_pkg

// >>> sync_bit.sv
// Two flip-flop synchroniser for one level.
// Assumes an asynchronous active-low reset of the destination domain.
`timescale 1ns/100ps

module sync_bit (
    input wire logic clk, // Destination clock
    input wire logic rst_n, // Destination reset, active low
    input wire logic d, // Asynchronous level
    output logic q // Synchronised level
);

    logic meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule : sync_bit

// >>> tap_fsm.sv
// Sixteen-state test access port controller.
// Assumes tms is launched on the test clock and test_reset_n resets it.
`timescale 1ns/100ps
`include "scan_port_defs.svh"

module tap_fsm (
    input wire logic tck, // Test clock
    input wire logic test_reset_n, // Test reset, active low
    input wire logic tms, // Mode select
    output scan_port_pkg::tap_state_t state // Current controller state
);

    scan_port_pkg::tap_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            scan_port_pkg::TEST_LOGIC_RESET: next_state = tms ? scan_port_pkg::TEST_LOGIC_RESET
                                                              : scan_port_pkg::RUN_TEST_IDLE;
            scan_port_pkg::RUN_TEST_IDLE: next_state = tms ? scan_port_pkg::SELECT_DR : scan_port_pkg::RUN_TEST_IDLE;
            scan_port_pkg::SELECT_DR: next_state = tms ? scan_port_pkg::SELECT_IR : scan_port_pkg::CAPTURE_DR;
            scan_port_pkg::CAPTURE_DR: next_state = tms ? scan_port_pkg::EXIT1_DR : scan_port_pkg::SHIFT_DR;
            scan_port_pkg::SHIFT_DR: next_state = tms ? scan_port_pkg::EXIT1_DR : scan_port_pkg::SHIFT_DR;
            scan_port_pkg::EXIT1_DR: next_state = tms ? scan_port_pkg::UPDATE_DR : scan_port_pkg::PAUSE_DR;
            scan_port_pkg::PAUSE_DR: next_state = tms ? scan_port_pkg::EXIT2_DR : scan_port_pkg::PAUSE_DR;
            scan_port_pkg::EXIT2_DR: next_state = tms ? scan_port_pkg::UPDATE_DR : scan_port_pkg::SHIFT_DR;
            scan_port_pkg::UPDATE_DR: next_state = tms ? scan_port_pkg::SELECT_DR : scan_port_pkg::RUN_TEST_IDLE;
            scan_port_pkg::SELECT_IR: next_state = tms ? scan_port_pkg::TEST_LOGIC_RESET
                                                       : scan_port_pkg::CAPTURE_IR;
            scan_port_pkg::CAPTURE_IR: next_state = tms ? scan_port_pkg::EXIT1_IR : scan_port_pkg::SHIFT_IR;
            scan_port_pkg::SHIFT_IR: next_state = tms ? scan_port_pkg::EXIT1_IR : scan_port_pkg::SHIFT_IR;
            scan_port_pkg::EXIT1_IR: next_state = tms ? scan_port_pkg::UPDATE_IR : scan_port_pkg::PAUSE_IR;
            scan_port_pkg::PAUSE_IR: next_state = tms ? scan_port_pkg::EXIT2_IR : scan_port_pkg::PAUSE_IR;
            scan_port_pkg::EXIT2_IR: next_state = tms ? scan_port_pkg::UPDATE_IR : scan_port_pkg::SHIFT_IR;
            scan_port_pkg::UPDATE_IR: next_state = tms ? scan_port_pkg::SELECT_DR : scan_port_pkg::RUN_TEST_IDLE;
            default: next_state = scan_port_pkg::TEST_LOGIC_RESET;
        endcase
    end

    // Held in reset while test reset is low, so tms and tck have no effect
    always_ff @(posedge tck or negedge test_reset_n) begin
        if (!test_reset_n) begin
            state <= scan_port_pkg::TEST_LOGIC_RESET;
        end else begin
            state <= next_state;
        end
    end

endmodule : tap_fsm

// >>> scan_emulator.sv
// Emulator model for the far side of the scan link.
// Assumes tdo out and enable come straight from the port; tck runs only in frames.
`timescale 1ns/100ps

module scan_emulator (
    output logic tck, // Test clock, still between frames
    output logic tms, // Mode select
    output logic tdi, // Data in
    input wire logic tdo_out, // Data out level
    input wire logic tdo_oe // Data out enable
);
    // Idle levels follow the pull-ups on tms and tdi
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One 30 ns period; inputs move only while tck is low, tdo read before the rise
    task automatic step(input logic m, input logic d, output logic o, output logic e);
        tms = m;
        tdi = d;
        #8;
        o = tdo_out;
        e = tdo_oe;
        tck = 1'b1;
        #15;
        tck = 1'b0;
        #7;
    endtask : step

    // From Run-Test-Idle: four bits through IR or the selected DR, back to idle
    task automatic shift(input logic ir, input logic [3:0] din, output logic [3:0] dout, output logic [3:0] oe);
        logic o;
        logic e;
        step(1'b1, 1'b1, o, e);
        if (ir) begin
            step(1'b1, 1'b1, o, e);
        end
        step(1'b0, 1'b1, o, e);
        step(1'b0, 1'b1, o, e);
        for (int i = 0; i < 4; i++) begin
            step(i == 3, din[i], dout[i], oe[i]);
        end
        step(1'b1, 1'b1, o, e);
        step(1'b0, 1'b1, o, e);
    endtask : shift

    // Five ones reach Test-Logic-Reset from anywhere, then a zero to idle
    task automatic to_idle();
        logic o;
        logic e;
        for (int i = 0; i < 5; i++) begin
            step(1'b1, 1'b1, o, e);
        end
        step(1'b0, 1'b1, o, e);
    endtask : to_idle
endmodule : scan_emulator

// >>> tb.sv
// Self-checking bench for the scan test port.
// Assumes the emulator model drives the link; event pins carry pull-ups.
`timescale 1ns/100ps

module tb;
    logic clk;
    logic rst_n;
    logic tck;
    logic tms;
    logic tdi;
    logic test_reset_n;
    logic tdo_out;
    logic tdo_oe;
    logic a_out;
    logic a_oe;
    logic b_out;
    logic b_oe;
    logic a_ext_en;
    logic b_ext_en;
    logic host_ready_core;
    logic host_int_core;
    logic hr_out;
    logic hr_oe;
    logic hi_out;
    logic hi_oe;
    logic scan_control;
    logic output_kill;
    logic emu_event_a;
    logic emu_event_b;
    logic a_lvl;
    logic b_lvl;
    logic [3:0] dout;
    logic [3:0] oe;
    int error_cnt;
    int cmp_count;

    // External parties only pull pins low; released pins rise on the pull-up
    assign a_lvl = a_oe ? a_out : (a_ext_en ? 1'b0 : 1'b1);
    assign b_lvl = b_oe ? b_out : (b_ext_en ? 1'b0 : 1'b1);

    scan_test_port_with_output_disable u_scan_test_port_with_output_disable (
        .clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .test_reset_n(test_reset_n),
        .tdo_out(tdo_out), .tdo_oe(tdo_oe), .emulator_event_pin_a_in(a_lvl),
        .emulator_event_pin_a_out(a_out), .emulator_event_pin_a_oe(a_oe),
        .emulator_event_pin_b_or_output_kill_in(b_lvl), .emulator_event_pin_b_or_output_kill_out(b_out),
        .emulator_event_pin_b_or_output_kill_oe(b_oe), .host_ready_core(host_ready_core),
        .host_int_core(host_int_core), .host_port_ready_out(hr_out), .host_port_ready_oe(hr_oe),
        .host_port_interrupt_out(hi_out), .host_port_interrupt_oe(hi_oe), .scan_control(scan_control),
        .output_kill(output_kill), .emu_event_a(emu_event_a), .emu_event_b(emu_event_b)
    );

    scan_emulator u_scan_emulator (
        .tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    // Pin levels need two sync flops and a register on clk
    task automatic settle();
        repeat (6) @(posedge clk);
        // Look away from the launching edge
        @(negedge clk);
    endtask : settle

    task automatic test_functional();
        u_scan_emulator.shift(1'b1, 4'h2, dout, oe);
        check("tdo_oe in shift", oe, 4'h0);
        settle();
        check("scan_control", {3'h0, scan_control}, 4'h0);
        check("pin oe", {2'h0, b_oe, a_oe}, 4'h0);
        check("event a", {3'h0, emu_event_a}, 4'h0);
    endtask : test_functional

    task automatic test_ir();
        @(posedge clk);
        test_reset_n <= 1'b1;
        settle();
        check("scan_control", {3'h0, scan_control}, 4'h1);
        u_scan_emulator.to_idle();
        u_scan_emulator.shift(1'b1, 4'h2, dout, oe);
        check("ir capture", dout, 4'h1);
        check("tdo_oe in shift", oe, 4'hF);
        check("tdo_oe idle", {3'h0, tdo_oe}, 4'h0);
    endtask : test_ir

    task automatic test_pins();
        u_scan_emulator.shift(1'b0, 4'hB, dout, oe);
        check("pin ctl", {b_out, b_oe, a_out, a_oe}, 4'hB);
        @(posedge clk);
        b_ext_en <= 1'b1;
        settle();
        check("events", {2'h0, emu_event_b, emu_event_a}, 4'h1);
        u_scan_emulator.shift(1'b0, 4'h4, dout, oe);
        check("pin capture", dout, 4'h3);
        check("pin ctl", {b_out, b_oe, a_out, a_oe}, 4'h4);
        @(posedge clk);
        b_ext_en <= 1'b0;
    endtask : test_pins

    task automatic test_bypass();
        logic [3:0] codes [2];
        codes = '{4'hF, 4'h5};
        foreach (codes[i]) begin
            u_scan_emulator.shift(1'b1, codes[i], dout, oe);
            check("ir capture", dout, 4'h1);
            u_scan_emulator.shift(1'b0, 4'hD, dout, oe);
            check("bypass delay", dout, 4'hA);
        end
    endtask : test_bypass

    task automatic test_kill();
        @(posedge clk);
        test_reset_n <= 1'b0;
        b_ext_en <= 1'b1;
        host_ready_core <= 1'b1;
        host_int_core <= 1'b1;
        settle();
        check("kill", {3'h0, output_kill}, 4'h1);
        check("host oe", {2'h0, hr_oe, hi_oe}, 4'h0);
        check("tdo and pin oe", {1'b0, tdo_oe, b_oe, a_oe}, 4'h0);
        check("event b", {3'h0, emu_event_b}, 4'h0);
        @(posedge clk);
        a_ext_en <= 1'b1;
        settle();
        check("kill pin a low", {3'h0, output_kill}, 4'h0);
        check("host pins", {hr_oe, hi_oe, hr_out, hi_out}, 4'hF);
        @(posedge clk);
        a_ext_en <= 1'b0;
        b_ext_en <= 1'b0;
        settle();
        check("kill pin b high", {3'h0, output_kill}, 4'h0);
    endtask : test_kill

    initial begin
        rst_n = 1'b0;
        test_reset_n = 1'b0;
        a_ext_en = 1'b0;
        b_ext_en = 1'b0;
        host_ready_core = 1'b0;
        host_int_core = 1'b0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        test_functional();
        test_ir();
        test_pins();
        test_bypass();
        test_kill();
        final_report();
    end

    // Whole run is well under 20 us
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
endmodule : tb
